// *** core/opp_top.sv ***
// Operation
// - After reset, with access low, mode select picks the algorithm.
// - Program strobe acts only in slave programming mode.
// - Strobe rising edge captures bus word and starts programming it.
// - Strobe falling edge ends the programming operation.
// - Verify goes high when the programmed word reads back right.
// - On failure verify stays low after the strobe rising edge.
// - In slave programming mode, latch input low makes the device read a command and address.
// - Bus drivers are open drain: device only pulls lines low.
`timescale 1ns/1ps
`include "opp_defs.svh"

module opp_top
	import opp_pkg::*;
#(
	parameter int DEPTH  = 256,
	parameter int ADDR_W = 8
) (
	input  wire logic                  I_CORE_CLK,
	input  wire logic                  I_RST_N,
	input  wire logic                  I_EXTERNAL_ACCESS_N,
	input  wire logic [3:0]            I_PROGRAMMING_MODE_SELECT,
	input  wire logic                  I_PROGRAM_STROBE_N,
	input  wire logic                  I_PROGRAMMING_LATCH_N,
	input  wire logic [`OPP_BUS_W-1:0] I_PROGRAMMING_BUS,
	output logic      [`OPP_BUS_W-1:0] O_PROGRAMMING_BUS,
	output logic      [`OPP_BUS_W-1:0] O_PROGRAMMING_BUS_OE,
	output logic                       O_PROGRAM_VERIFY_OK
);
	// The word address must fit below the command field of the bus
	if (DEPTH < 2 || DEPTH > (1 << ADDR_W) ||
	    ADDR_W > `OPP_ADDR_MSB + 1) begin : g_bad_params
		$error("opp_top: DEPTH or ADDR_W out of range");
	end

	// Synchronisers: index 0 strobe, index 1 latch
	logic [1:0] meta;
	logic [1:0] sync;
	logic [1:0] sync_d;
	logic [1:0] next_meta;
	logic [1:0] next_sync;
	logic [1:0] next_sync_d;
	logic [1:0] pins;

	assign pins = {I_PROGRAMMING_LATCH_N, I_PROGRAM_STROBE_N};

	always_comb begin
		next_meta   = pins;
		next_sync   = meta;
		next_sync_d = sync;
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			meta   <= `OPP_SYNC_RESET;
			sync   <= `OPP_SYNC_RESET;
			sync_d <= `OPP_SYNC_RESET;
		end else begin
			meta   <= next_meta;
			sync   <= next_sync;
			sync_d <= next_sync_d;
		end
	end

	logic strobe_rise;
	logic strobe_fall;
	logic latch_on;

	assign strobe_rise = sync[0] & ~sync_d[0];
	assign strobe_fall = ~sync[0] & sync_d[0];
	assign latch_on    = ~sync[1];

	// Mode capture, once after reset release
	opp_mode_t mode;
	opp_mode_t next_mode;
	logic      mode_taken;
	logic      next_mode_taken;

	always_comb begin
		next_mode       = mode;
		next_mode_taken = 1'b1;
		if (!mode_taken) begin
			if (I_EXTERNAL_ACCESS_N ||
			    I_PROGRAMMING_MODE_SELECT == `OPP_MODE_NONE) begin
				next_mode = OPP_RUN;
			end else if (I_PROGRAMMING_MODE_SELECT == `OPP_MODE_SLAVE) begin
				next_mode = OPP_SLAVE;
			end else begin
				next_mode = OPP_OTHER;
			end
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			mode       <= OPP_RUN;
			mode_taken <= 1'b0;
		end else begin
			mode       <= next_mode;
			mode_taken <= next_mode_taken;
		end
	end

	logic slave;
	assign slave = mode_taken && (mode == OPP_SLAVE);

	// Command and address latch, programming sequencer
	opp_array_if #(.ADDR_W(ADDR_W), .DATA_W(`OPP_BUS_W)) arr ();

	opp_state_t            state;
	opp_state_t            next_state;
	logic [1:0]            cmd;
	logic [1:0]            next_cmd;
	logic [ADDR_W-1:0]     addr;
	logic [ADDR_W-1:0]     next_addr;
	logic [`OPP_BUS_W-1:0] data;
	logic [`OPP_BUS_W-1:0] next_data;
	logic                  verify;
	logic                  next_verify;

	always_comb begin
		next_state  = state;
		next_cmd    = cmd;
		next_addr   = addr;
		next_data   = data;
		next_verify = verify;
		if (slave && latch_on) begin
			next_cmd  = I_PROGRAMMING_BUS[`OPP_CMD_MSB:`OPP_CMD_LSB];
			next_addr = I_PROGRAMMING_BUS[ADDR_W-1:0];
		end
		if (slave) begin
			unique case (state)
				OPP_IDLE: begin
					if (strobe_rise && cmd == `OPP_CMD_PROGRAM) begin
						next_data   = I_PROGRAMMING_BUS;
						next_verify = 1'b0;
						next_state  = OPP_WRITE;
					end
				end
				OPP_WRITE: begin
					next_state = strobe_fall ? OPP_IDLE : OPP_CHECK;
				end
				OPP_CHECK: begin
					next_verify = (arr.rdata == data);
					next_state  = strobe_fall ? OPP_IDLE : OPP_HOLD;
				end
				OPP_HOLD: begin
					if (strobe_fall) begin
						next_state = OPP_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			state  <= OPP_IDLE;
			cmd    <= `OPP_CMD_PROGRAM;
			addr   <= '0;
			data   <= `OPP_ERASED_WORD;
			verify <= 1'b0;
		end else begin
			state  <= next_state;
			cmd    <= next_cmd;
			addr   <= next_addr;
			data   <= next_data;
			verify <= next_verify;
		end
	end

	assign arr.addr  = addr;
	assign arr.wdata = data;
	assign arr.we    = (state == OPP_WRITE) && !strobe_fall;

	opp_array #(
		.DEPTH (DEPTH),
		.ADDR_W(ADDR_W)
	) u_array (
		.i_clk  (I_CORE_CLK),
		.i_rst_n(I_RST_N),
		.port_a (arr.array)
	);

	// Open-drain bus and verify output
	logic [`OPP_BUS_W-1:0] bus_oe;
	logic [`OPP_BUS_W-1:0] next_bus_oe;
	logic                  verify_q;
	logic                  next_verify_q;

	always_comb begin
		next_bus_oe = '0;
		if (slave && !latch_on && cmd == `OPP_CMD_DUMP) begin
			next_bus_oe = ~arr.rdata;
		end
		next_verify_q = (mode != OPP_RUN) && next_verify;
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			bus_oe   <= '0;
			verify_q <= 1'b0;
		end else begin
			bus_oe   <= next_bus_oe;
			verify_q <= next_verify_q;
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_PROGRAMMING_BUS <= `OPP_BUS_RESET;
		end else begin
			O_PROGRAMMING_BUS <= `OPP_BUS_RESET;
		end
	end

	assign O_PROGRAMMING_BUS_OE = bus_oe;
	assign O_PROGRAM_VERIFY_OK  = verify_q;
endmodule : opp_top

// *** core/opp_defs.svh ***
`ifndef OPP_DEFS_SVH
`define OPP_DEFS_SVH

// Programming bus width and command field layout
`define OPP_BUS_W        16
`define OPP_CMD_MSB      15
`define OPP_CMD_LSB      14
`define OPP_ADDR_MSB     13

// Commands carried in the latched word
`define OPP_CMD_PROGRAM  2'h0
`define OPP_CMD_DUMP     2'h1

// Mode select code for slave programming; zero means no programming
`define OPP_MODE_NONE    4'h0
`define OPP_MODE_SLAVE   4'hC

// Erased array word and reset values
`define OPP_ERASED_WORD  16'hFFFF
`define OPP_BUS_RESET    16'h0000

// Synchroniser reset levels match idle pins: latch high, strobe low
`define OPP_SYNC_RESET   2'h2

`endif

// *** core/opp_pkg.sv ***
package opp_pkg;

	typedef enum logic [1:0] {
		OPP_RUN   = 2'b00,
		OPP_SLAVE = 2'b01,
		OPP_OTHER = 2'b11
	} opp_mode_t;

	// Gray codes along idle -> write -> check -> hold
	typedef enum logic [1:0] {
		OPP_IDLE  = 2'b00,
		OPP_WRITE = 2'b01,
		OPP_CHECK = 2'b11,
		OPP_HOLD  = 2'b10
	} opp_state_t;

endpackage : opp_pkg

// *** core/opp_array_if.sv ***
`timescale 1ns/1ps

interface opp_array_if #(
	parameter int ADDR_W = 8,
	parameter int DATA_W = 16
);
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic              we;
	logic [DATA_W-1:0] rdata;

	modport ctrl  (output addr, output wdata, output we, input rdata);
	modport array (input addr, input wdata, input we, output rdata);
endinterface : opp_array_if

// *** core/opp_array.sv ***
`timescale 1ns/1ps
`include "opp_defs.svh"

// One-time array: programming can only clear bits of an erased word
module opp_array #(
	parameter int DEPTH  = 256,
	parameter int ADDR_W = 8
) (
	input  wire logic  i_clk,
	input  wire logic  i_rst_n,
	opp_array_if.array port_a
);
	if (DEPTH < 1 || DEPTH > (1 << ADDR_W)) begin : g_bad_depth
		$error("opp_array: DEPTH does not fit ADDR_W");
	end

	logic [`OPP_BUS_W-1:0] mem      [DEPTH];
	logic [`OPP_BUS_W-1:0] next_mem [DEPTH];

	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			next_mem[i] = mem[i];
		end
		if (port_a.we && (int'(port_a.addr) < DEPTH)) begin
			next_mem[port_a.addr] = mem[port_a.addr] & port_a.wdata;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= `OPP_ERASED_WORD;
			end
		end else begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= next_mem[i];
			end
		end
	end

	assign port_a.rdata = (int'(port_a.addr) < DEPTH) ?
		mem[port_a.addr] : `OPP_ERASED_WORD;
endmodule : opp_array

// *** verification/opp_program_strobe_n_model.sv ***
`timescale 1ns/1ps
module opp_program_strobe_n_model (
	input  wire logic [15:0] i_oe,
	input  wire logic [15:0] i_out,
	input  wire logic [15:0] i_drv,
	input  wire logic        i_drv_en,
	output wire logic [15:0] o_bus
);
	// Pull-ups hold released lines high; device and programmer wire-AND
	assign o_bus = (i_drv_en ? i_drv : 16'hFFFF) & ~(i_oe & ~i_out);
endmodule : opp_program_strobe_n_model

// *** verification/opp_top_monitor.sv ***
`timescale 1ns/1ps
module opp_top_monitor #(
	parameter int DEPTH  = 256,
	parameter int ADDR_W = 8
) (
	input wire logic			I_CORE_CLK,
	input wire logic			I_RST_N,
	input wire logic			I_EXTERNAL_ACCESS_N,
	input wire logic [3:0]		I_PROGRAMMING_MODE_SELECT,
	input wire logic			I_PROGRAM_STROBE_N,
	input wire logic			I_PROGRAMMING_LATCH_N,
	input wire logic [15:0]	O_PROGRAMMING_BUS,
	input wire logic [15:0]	O_PROGRAMMING_BUS_OE,
	input wire logic			O_PROGRAM_VERIFY_OK
);
	wire v = O_PROGRAM_VERIFY_OK;
	wire s = I_PROGRAM_STROBE_N;
	logic seen, slave, prev;
	logic [3:0] age;
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RST_N);
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			{seen, slave, prev, age} <= 7'h00;
		end else begin
			slave <= seen ? slave : (!I_EXTERNAL_ACCESS_N
				&& I_PROGRAMMING_MODE_SELECT == 4'hC);
			seen <= 1'h1;
			prev <= s;
			age <= (s != prev) ? 4'h0 : age + {3'h0, age != 4'hF};
		end
	end
	a_open_drain: assert property (
		O_PROGRAMMING_BUS == 16'h0000) else $error("bus driven");
	a_run_quiet: assert property (
		!slave |-> !v) else $error("verify in wrong mode");
	a_run_release: assert property (
		!slave |-> O_PROGRAMMING_BUS_OE == 16'h0000) else $error("bus pulled");
	a_rise_time: assert property (
		$rose(v) |-> s && age inside {[2:7]}) else $error("verify rise");
	a_fall_time: assert property (
		$fell(v) |-> age <= 4'h5) else $error("verify fall");
	a_low_hold: assert property (
		!s && age >= 4'h4 |-> $stable(v)) else $error("verify moved low");
	a_high_hold: assert property (
		s && age >= 4'h8 |-> $stable(v)) else $error("verify moved high");
	a_dump_latch: assert property (
		$rose(|O_PROGRAMMING_BUS_OE) |-> I_PROGRAMMING_LATCH_N)
		else $error("dump during latch");
endmodule : opp_top_monitor
bind opp_top opp_top_monitor #(.DEPTH(DEPTH), .ADDR_W(ADDR_W)) mon (.*);

// *** verification/opp_top_tb.sv ***
`timescale 1ns/1ps
`include "opp_defs.svh"
module opp_top_tb;
	logic clk = 1'h0, rst_n = 1'h0, acc_n = 1'h0;
	logic stb_n = 1'h0, lat_n = 1'h1, den = 1'h0;
	logic [3:0] mode = 4'hC;
	logic [15:0] drv = 16'h0000;
	logic [16:0] exq[$], e, g;
	logic [31:0] rs = 32'h0001_0CCF;
	wire [15:0] bus, oe, obus;
	wire ok;
	int error_cnt = 0, n_checks = 0;
	event smp;
	initial forever #2.5 clk = ~clk;
	opp_top dut (.I_CORE_CLK(clk), .I_RST_N(rst_n),
		.I_EXTERNAL_ACCESS_N(acc_n), .I_PROGRAMMING_MODE_SELECT(mode),
		.I_PROGRAM_STROBE_N(stb_n), .I_PROGRAMMING_LATCH_N(lat_n),
		.I_PROGRAMMING_BUS(bus), .O_PROGRAMMING_BUS(obus),
		.O_PROGRAMMING_BUS_OE(oe), .O_PROGRAM_VERIFY_OK(ok));
	opp_program_strobe_n_model pm (.i_oe(oe), .i_out(obus), .i_drv(drv),
		.i_drv_en(den), .o_bus(bus));
	function logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction : xs
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task rst(input logic [3:0] m, input logic a);
		rst_n = 1'h0;
		{mode, acc_n} = {m, a};
		cyc(16);
		rst_n = 1'h1;
		cyc(4);
	endtask : rst
	task lat(input logic [15:0] x);
		{drv, den} = {x, 1'h1};
		lat_n = 1'h0;
		cyc(6);
		lat_n = 1'h1;
		cyc(4);
	endtask : lat
	// Let the checker sample before any input moves again
	task note(input logic [16:0] x);
		exq.push_back(x);
		->smp;
		cyc(1);
	endtask : note
	task program_strobe_n(input logic [7:0] a, input logic [15:0] d, input logic v);
		lat({`OPP_CMD_PROGRAM, 6'h00, a});
		drv = d;
		cyc(2);
		stb_n = 1'h1;
		cyc(3);
		note({16'h0000, 1'h0});
		cyc(4);
		note({16'h0000, v});
		stb_n = 1'h0;
		cyc(3);
	endtask : program_strobe_n
	task dump(input logic [7:0] a, input logic [15:0] x);
		lat({`OPP_CMD_DUMP, 6'h00, a});
		den = 1'h0;
		cyc(2);
		note({1'h1, x});
	endtask : dump
	task results;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results
	initial forever begin
		@smp;
		e = exq.pop_front();
		g = e[16] ? {1'h1, bus} : {16'h0000, ok};
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h got %h",
				e[16] ? "bus" : "verify", e, g);
		end
	end
	initial begin
		#40000;
		error_cnt++;
		results;
	end
	initial begin
		rst(`OPP_MODE_SLAVE, 1'h0);
		program_strobe_n(8'h01, 16'h1234, 1'h1);
		program_strobe_n(8'h01, 16'h1235, 1'h0);
		dump(8'h01, 16'h1234);
		for (int i = 2; i < 6; i++) begin
			rs = xs(rs);
			program_strobe_n({rs[19:16], i[3:0]}, rs[15:0], 1'h1);
			dump({rs[19:16], i[3:0]}, rs[15:0]);
		end
		rst(4'h3, 1'h0);
		program_strobe_n(8'h02, 16'h0000, 1'h0);
		dump(8'h02, 16'hFFFF);
		rst(`OPP_MODE_SLAVE, 1'h1);
		program_strobe_n(8'h02, 16'h0000, 1'h0);
		dump(8'h02, 16'hFFFF);
		rst(`OPP_MODE_NONE, 1'h0);
		program_strobe_n(8'h02, 16'h0000, 1'h0);
		results;
	end
endmodule : opp_top_tb
